// ---- verif/lcdie_engine_bench.sv ----
// Purpose: Self-checking bench for the instruction engine.
// Assumes: Shortened execution and blink counts.
// Notes: The host waits for the busy flag to clear before each new request, except the flag read issued during the clear.
`timescale 1ns/1ps
`default_nettype none
module lcdie_engine_bench;
  import lcdie_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic strobe_pin, reg_select, read_sel, host_bus_oe, exec_pending_flag, sel_text;
  logic step_up, window_follow, cursor_flash_on;
  logic [7:0] host_bus_in, host_bus_out, scan_char, q;
  logic [6:0] addr_pointer, window_offset;
  logic [6:0] scan_addr = 7'h00;
  logic [4:0] common_rows;
  lcdie_disp_t disp;
  lcdie_func_t func;
  lcdie_duty_t duty;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] sc [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
  logic [7:0] sp [4] = '{8'h04, 8'h05, 8'h05, 8'h05};
  logic [7:0] so [4] = '{8'h01, 8'h01, 8'h02, 8'h01};
  always #2.5 mclk = ~mclk;
  lcdie_engine #(.EXEC_CYC(20), .LONG_CYC(200), .BLINK_CYC(16)) u_lcdie_engine (
    .mclk(mclk), .sys_rst(sys_rst), .strobe_pin(strobe_pin), .reg_select(reg_select),
    .read_sel(read_sel), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .exec_pending_flag(exec_pending_flag),
    .addr_pointer(addr_pointer), .sel_text(sel_text), .step_up(step_up),
    .window_follow(window_follow), .window_offset(window_offset), .disp(disp), .func(func),
    .common_rows(common_rows), .duty(duty), .cursor_flash_on(cursor_flash_on),
    .scan_addr(scan_addr), .scan_char(scan_char));
  lcdie_host_model u_lcdie_host_model (.mclk(mclk), .strobe_pin(strobe_pin),
    .reg_select(reg_select), .read_sel(read_sel), .host_bus_in(host_bus_in),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Waits for busy to rise and fall; data accesses also wait out the pointer step.
  task automatic wait_idle(input logic data);
    int n;
    n = 0;
    while (exec_pending_flag !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    if (exec_pending_flag !== 1'b1)
      check(8'hEE, 8'h01);
    while (exec_pending_flag !== 1'b0 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400)
      check(8'hEE, 8'h00);
    if (data)
      repeat (1210) @(negedge mclk);
  endtask
  task automatic send(input logic rs, input logic rd, input logic [7:0] d);
    u_lcdie_host_model.xfer(rs, rd, d, q);
    wait_idle(rs);
  endtask
  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    scan_addr = a;
    repeat (3) @(negedge mclk);
    check(scan_char, exp);
  endtask
  initial
  begin
    int cnt;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    check({3'b0, common_rows}, 8'h08);
    send(0, 0, 8'h38);
    check({3'b0, common_rows}, 8'h10);
    check({6'b0, duty}, 8'h02);
    check({5'b0, func}, 8'h06);
    send(0, 0, 8'h04);
    send(0, 0, 8'h34);
    check({3'b0, common_rows}, 8'h10);
    check({5'b0, func}, 8'h06);
    send(0, 0, 8'h8A);
    u_lcdie_host_model.xfer(0, 0, 8'h01, q);
    u_lcdie_host_model.xfer(0, 1, 8'h00, q);
    check(q, 8'h8A);
    wait_idle(0);
    check({step_up, addr_pointer}, 8'h80);
    peek(7'h4F, 8'h20);
    send(0, 0, 8'h07);
    check({6'b0, step_up, window_follow}, 8'h03);
    send(0, 0, 8'h85);
    check({sel_text, addr_pointer}, 8'h85);
    send(1, 0, 8'h41);
    check({1'b0, addr_pointer}, 8'h06);
    check({1'b0, window_offset}, 8'h01);
    peek(7'h05, 8'h41);
    send(0, 0, 8'h43);
    check({sel_text, addr_pointer}, 8'h03);
    send(1, 0, 8'h1F);
    check({1'b0, window_offset}, 8'h01);
    send(0, 0, 8'h43);
    send(1, 1, 8'h00);
    check(q, 8'h1F);
    check({window_offset, 1'b0}, 8'h02);
    check({1'b0, addr_pointer}, 8'h04);
    send(0, 0, 8'h85);
    for (int i = 0; i < 4; i++)
    begin
      send(0, 0, sc[i]);
      check({1'b0, addr_pointer}, sp[i]);
      check({1'b0, window_offset}, so[i]);
    end
    send(0, 0, 8'h43);
    send(0, 0, 8'h10);
    check({sel_text, addr_pointer}, 8'h82);
    send(1, 1, 8'h00);
    check(q, 8'h20);
    send(0, 0, 8'h0F);
    check({5'b0, disp}, 8'h07);
    send(0, 0, 8'h0B);
    check({disp, addr_pointer[4:0]}, 8'h63);
    cnt = 0;
    repeat (64)
    begin
      @(negedge mclk);
      cnt += int'(cursor_flash_on === 1'b1);
    end
    check(8'(cnt), 8'h20);
    send(0, 0, 8'h0A);
    check({7'b0, cursor_flash_on}, 8'h00);
    send(0, 0, 8'h02);
    check({window_offset, 1'b0}, 8'h00);
    check({1'b0, addr_pointer}, 8'h00);
    peek(7'h05, 8'h41);
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    check({5'b0, func}, 8'h04);
    send(0, 0, 8'h24);
    check({5'b0, func}, 8'h01);
    check({3'b0, common_rows}, 8'h0B);
    check({6'b0, duty}, 8'h01);
    u_lcdie_host_model.xfer4(0, 0, 8'h85, q);
    wait_idle(0);
    check({sel_text, addr_pointer}, 8'h85);
    u_lcdie_host_model.xfer4(0, 1, 8'h00, q);
    check(q, 8'h05);
    u_lcdie_host_model.xfer4(1, 0, 8'h5A, q);
    wait_idle(1);
    peek(7'h05, 8'h5A);
    give_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule // lcdie_engine_bench
`default_nettype wire

// ---- verif/lcdie_host_model.sv ----
// Purpose: Host microcontroller model on the parallel pins of the engine.
// Assumes: Pins change on the falling edge of mclk; either bus width.
// Notes: Between transfers the bus shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module lcdie_host_model (
  input wire logic mclk,
  output logic strobe_pin,
  output logic reg_select,
  output logic read_sel,
  output logic [7:0] host_bus_in,
  input wire logic [7:0] host_bus_out,
  input wire logic host_bus_oe
);
  initial
  begin
    strobe_pin = 1'b0;
    reg_select = 1'b0;
    read_sel = 1'b0;
    host_bus_in = 8'h00;
  end
  // One whole byte per strobe; read data is taken just before the strobe falls.
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    reg_select = rs;
    read_sel = rd;
    host_bus_in = d;
    strobe_pin = 1'b1;
    repeat (6) @(negedge mclk);
    q = host_bus_oe ? host_bus_out : ~host_bus_out;
    strobe_pin = 1'b0;
    repeat (4) @(negedge mclk);
    host_bus_in = ~d;
  endtask
  // Narrow bus: two strobes per byte, high nibble first, each on bus bits 7 to 4.
  task automatic xfer4(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    xfer(rs, rd, {d[7:4], 4'h0}, hi);
    xfer(rs, rd, {d[3:0], 4'h0}, lo);
    q = {hi[7:4], lo[7:4]};
  endtask
endmodule // lcdie_host_model
`default_nettype wire

// ---- verilog/lcdie_engine.sv ----
// Purpose: Instruction decoder and executor of a dot-matrix character display controller.
// Assumes: Host pins are asynchronous to mclk; one instruction is held while busy.
// Notes: Execution times are fixed counts of mclk at the nominal oscillator rate.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Text address set loads pointer, selects text
// - Glyph address set loads pointer, selects glyph
// - Flag read returns busy bit and pointer
// - Returned pointer predates the executing instruction
// - Busy flag high exactly while executing
// - Ordinary instructions finish in forty microseconds
// - Data write stores byte, steps, maybe shifts
// - Data read returns byte, steps, never shifts
// - Read data valid only after address set or read
// - Cursor shift acts as text address set
// - Clear fills spaces, zeroes pointer, forces increment
// - Home zeroes pointer and window, keeps text
// - Step direction chooses increment or decrement
// - Window follows only on text writes
// - On/off sets three display flags only
// - Flash alternates cursor cell at blink interval
// - Shift codes move pointer or window
// - Narrow bus moves each byte as nibbles
// - Row and glyph settings pick duty
// - Row and glyph settings lock after use
// - Common row count follows display mode
// - Pointer steps after busy clears, delayed
// - Leading one bit selects instruction
module lcdie_engine #(
  parameter int unsigned EXEC_CYC = lcdie_pkg::EXEC_CYC,
  parameter int unsigned LONG_CYC = lcdie_pkg::LONG_CYC,
  parameter int unsigned BLINK_CYC = lcdie_pkg::BLINK_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic strobe_pin,
  input wire logic reg_select,
  input wire logic read_sel,
  input wire logic [7:0] host_bus_in,
  output logic [7:0] host_bus_out,
  output logic host_bus_oe,
  output logic exec_pending_flag,
  output logic [6:0] addr_pointer,
  output logic sel_text,
  output logic step_up,
  output logic window_follow,
  output logic [6:0] window_offset,
  output lcdie_pkg::lcdie_disp_t disp,
  output lcdie_pkg::lcdie_func_t func,
  output logic [4:0] common_rows,
  output lcdie_pkg::lcdie_duty_t duty,
  output logic cursor_flash_on,
  input wire logic [6:0] scan_addr,
  output logic [7:0] scan_char
);
  import lcdie_pkg::*;

  lcdie_xfer_t xfer;
  lcdie_xfer_t cmd_r;
  lcdie_state_t state_r;
  lcdie_op_t op;
  lcdie_op_t op_r;
  logic xfer_valid;
  logic cmd_valid_r;
  logic take;
  logic [31:0] cnt_r;
  logic [31:0] len_r;
  logic busy_done;
  logic step_done;
  logic [6:0] addr_snap_r;
  logic [7:0] read_latch_r;
  logic [7:0] flag_byte;
  logic func_seen_r;
  logic func_locked_r;
  logic blink_tick;
  logic blink_phase_r;
  logic [7:0] text_ram [TEXT_DEPTH];
  logic [7:0] glyph_ram [GLYPH_DEPTH];

  // ==========================================================================
  // Helpers
  function automatic lcdie_op_t decode(input lcdie_xfer_t x);
    if (x.rs)
      return x.rd ? OP_READ : OP_WRITE;
    if (x.rd)
      return OP_NONE;
    if (x.data[7])
      return OP_TEXT;
    if (x.data[6])
      return OP_GLYPH;
    if (x.data[5])
      return OP_FUNC;
    if (x.data[4])
      return OP_SHIFT;
    if (x.data[3])
      return OP_ONOFF;
    if (x.data[2])
      return OP_ENTRY;
    if (x.data[1])
      return OP_HOME;
    if (x.data[0])
      return OP_CLEAR;
    return OP_NONE;
  endfunction

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up,
                                          input logic text);
    logic [6:0] n;
    n = up ? p + 7'h01 : p - 7'h01;
    return text ? n : {1'b0, n[5:0]};
  endfunction

  function automatic logic [6:0] win_move(input logic [6:0] w, input logic left,
                                          input logic two);
    logic [6:0] len;
    len = two ? ROW_LEN_TWO : ROW_LEN_ONE;
    if (left)
      return (w == len - 7'h01) ? 7'h00 : w + 7'h01;
    return (w == 7'h00) ? len - 7'h01 : w - 7'h01;
  endfunction

  function automatic logic [7:0] ram_rd(input logic text, input logic [6:0] a);
    return text ? text_ram[a] : glyph_ram[a[5:0]];
  endfunction

  // ==========================================================================
  // Host pins
  assign flag_byte = {exec_pending_flag, addr_snap_r};

  lcdie_host_port u_port (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .strobe_pin(strobe_pin),
    .reg_select_pin(reg_select),
    .read_sel_pin(read_sel),
    .host_bus_in(host_bus_in),
    .wide_bus(func.wide_bus),
    .flag_byte(flag_byte),
    .read_byte(read_latch_r),
    .xfer(xfer),
    .xfer_valid(xfer_valid),
    .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe)
  );

  // ==========================================================================
  // Command holding and sequencing
  assign op = decode(cmd_r);
  assign take = (state_r == ST_IDLE) && cmd_valid_r;
  assign busy_done = (state_r == ST_BUSY) && (cnt_r == len_r - 32'h00000001);
  assign step_done = (state_r == ST_STEP) && (cnt_r == 32'(STEP_CYC - 1));

  // Flag reads never queue, so they are answered even during execution.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmd_valid_r <= 1'b0;
      cmd_r <= '0;
    end
    else if (xfer_valid && (xfer.rs || !xfer.rd))
    begin
      cmd_valid_r <= 1'b1;
      cmd_r <= xfer;
    end
    else if (take)
      cmd_valid_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      cnt_r <= 32'h00000000;
      len_r <= 32'h00000001;
      exec_pending_flag <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (take)
          begin
            state_r <= ST_BUSY;
            op_r <= op;
            cnt_r <= 32'h00000000;
            exec_pending_flag <= 1'b1;
            if (op == OP_CLEAR || op == OP_HOME)
              len_r <= 32'(LONG_CYC);
            else
              len_r <= 32'(EXEC_CYC);
          end
        ST_BUSY:
          if (busy_done)
          begin
            exec_pending_flag <= 1'b0;
            cnt_r <= 32'h00000000;
            state_r <= (op_r == OP_WRITE || op_r == OP_READ) ? ST_STEP : ST_IDLE;
          end
          else
            cnt_r <= cnt_r + 32'h00000001;
        ST_STEP:
          if (step_done)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 32'h00000001;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Address pointer, RAM selection and snapshot
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      addr_pointer <= 7'h00;
      sel_text <= RST_SEL_TEXT;
      addr_snap_r <= 7'h00;
    end
    else
    begin
      if (state_r == ST_IDLE)
        addr_snap_r <= addr_pointer;
      if (take)
      begin
        case (op)
          OP_CLEAR, OP_HOME: addr_pointer <= 7'h00;
          OP_TEXT:
          begin
            addr_pointer <= cmd_r.data[6:0];
            sel_text <= 1'b1;
          end
          OP_GLYPH:
          begin
            addr_pointer <= {1'b0, cmd_r.data[5:0]};
            sel_text <= 1'b0;
          end
          OP_SHIFT:
            if (!cmd_r.data[3])
            begin
              addr_pointer <= step_ptr(addr_pointer, cmd_r.data[2], 1'b1);
              sel_text <= 1'b1;
            end
          default: addr_pointer <= addr_pointer;
        endcase
      end
      else if (step_done)
        addr_pointer <= step_ptr(addr_pointer, step_up, sel_text);
    end
  end

  // ==========================================================================
  // Text and glyph RAM; clear writes one space per cycle over the first TEXT_DEPTH busy cycles.
  always_ff @(posedge mclk)
  begin
    if (take && op == OP_WRITE)
    begin
      if (sel_text)
        text_ram[addr_pointer] <= cmd_r.data;
      else
        glyph_ram[addr_pointer[5:0]] <= cmd_r.data;
    end
    else if (state_r == ST_BUSY && op_r == OP_CLEAR && cnt_r < 32'(TEXT_DEPTH))
      text_ram[cnt_r[6:0]] <= SPACE_CODE;
  end

  always_ff @(posedge mclk)
  begin
    scan_char <= text_ram[scan_addr];
  end

  // Read latch is refreshed only by address sets, cursor moves and reads.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      read_latch_r <= 8'h00;
    else if (take && op == OP_TEXT)
      read_latch_r <= text_ram[cmd_r.data[6:0]];
    else if (take && op == OP_GLYPH)
      read_latch_r <= glyph_ram[cmd_r.data[5:0]];
    else if (take && op == OP_SHIFT && !cmd_r.data[3])
      read_latch_r <= text_ram[step_ptr(addr_pointer, cmd_r.data[2], 1'b1)];
    else if (step_done && op_r == OP_READ)
      read_latch_r <= ram_rd(sel_text, step_ptr(addr_pointer, step_up, sel_text));
  end

  // ==========================================================================
  // Modes and display window
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      step_up <= RST_STEP_UP;
      window_follow <= 1'b0;
      disp <= '0;
      func <= '{wide_bus: RST_WIDE_BUS, two_row: 1'b0, tall_glyph: 1'b0};
      func_seen_r <= 1'b0;
      func_locked_r <= 1'b0;
    end
    else if (take)
    begin
      if (op != OP_FUNC && func_seen_r)
        func_locked_r <= 1'b1;
      case (op)
        OP_CLEAR: step_up <= 1'b1;
        OP_ENTRY:
        begin
          step_up <= cmd_r.data[1];
          window_follow <= cmd_r.data[0];
        end
        OP_ONOFF: disp <= cmd_r.data[2:0];
        OP_FUNC:
        begin
          func_seen_r <= 1'b1;
          func.wide_bus <= cmd_r.data[4];
          if (!func_locked_r)
          begin
            func.two_row <= cmd_r.data[3];
            func.tall_glyph <= cmd_r.data[2];
          end
        end
        default: func_seen_r <= func_seen_r;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      window_offset <= 7'h00;
    else if (take && (op == OP_CLEAR || op == OP_HOME))
      window_offset <= 7'h00;
    else if (take && op == OP_SHIFT && cmd_r.data[3])
      window_offset <= win_move(window_offset, !cmd_r.data[2], func.two_row);
    else if (step_done && op_r == OP_WRITE && window_follow && sel_text)
      window_offset <= win_move(window_offset, step_up, func.two_row);
  end

  // ==========================================================================
  // Panel mode and blink
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      common_rows <= ROWS_ONE_SHORT;
      duty <= DUTY_8;
    end
    else if (func.two_row)
    begin
      common_rows <= ROWS_TWO;
      duty <= DUTY_16;
    end
    else if (func.tall_glyph)
    begin
      common_rows <= ROWS_ONE_TALL;
      duty <= DUTY_11;
    end
    else
    begin
      common_rows <= ROWS_ONE_SHORT;
      duty <= DUTY_8;
    end
  end

  lcdie_pulse_div #(.PERIOD(BLINK_CYC)) u_blink (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(blink_tick)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      blink_phase_r <= 1'b0;
      cursor_flash_on <= 1'b0;
    end
    else
    begin
      if (blink_tick)
        blink_phase_r <= ~blink_phase_r;
      cursor_flash_on <= disp.flash_at_cursor & blink_phase_r;
    end
  end

  // ==========================================================================
  // Checks
  logic [31:0] busy_run_r;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !exec_pending_flag)
      busy_run_r <= 32'h00000000;
    else
      busy_run_r <= busy_run_r + 32'h00000001;
  end

  chk_text_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == OP_TEXT |=> addr_pointer == $past(cmd_r.data[6:0]) && sel_text)
    else $error("text address set did not load pointer");
  chk_glyph_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == OP_GLYPH |=> addr_pointer == {1'b0, $past(cmd_r.data[5:0])} && !sel_text)
    else $error("glyph address set did not load pointer");
  chk_flag_snap: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> flag_byte == {1'b1, $past(addr_pointer)})
    else $error("flag read does not show prior pointer");
  chk_busy_length: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(exec_pending_flag) |-> $past(busy_run_r) + 32'h00000001 == len_r)
    else $error("busy time differs from execution length");
  chk_busy_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> exec_pending_flag ##1 exec_pending_flag)
    else $error("busy flag not raised on execution");
  chk_step_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == ST_STEP && $past(state_r) == ST_STEP |-> $stable(addr_pointer)
      && !exec_pending_flag)
    else $error("pointer moved during update delay");
  chk_clear_effect: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == OP_CLEAR |=> addr_pointer == 7'h00 && step_up && window_offset == 7'h00)
    else $error("clear left pointer, step or window");
  chk_func_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == OP_FUNC && func_locked_r |=> $stable(func.two_row) && $stable(func.tall_glyph))
    else $error("locked row settings changed");
  chk_read_noshift: assert property (@(posedge mclk) disable iff (sys_rst)
    step_done && op_r == OP_READ |=> $stable(window_offset))
    else $error("data read shifted window");
  chk_rows_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    func.two_row |=> common_rows == ROWS_TWO && duty == DUTY_16)
    else $error("two row mode has wrong common count");

  cov_clear: cover property (@(posedge mclk) disable iff (sys_rst) take && op == OP_CLEAR);
  cov_read: cover property (@(posedge mclk) disable iff (sys_rst) step_done && op_r == OP_READ);
  cov_follow: cover property (@(posedge mclk) disable iff (sys_rst)
    step_done && op_r == OP_WRITE && window_follow);
  cov_flag_busy: cover property (@(posedge mclk) disable iff (sys_rst)
    host_bus_oe && exec_pending_flag);
endmodule // lcdie_engine
`default_nettype wire

// ---- verilog/lcdie_host_port.sv ----
// Purpose: Host pin front end: synchronises strobe, select and bus, joins nibbles.
// Assumes: A transfer completes on the falling edge of the strobe.
// Notes: In narrow mode the high nibble travels first on bus bits 7 to 4.
`timescale 1ns/1ps
`default_nettype none
module lcdie_host_port (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic strobe_pin,
  input wire logic reg_select_pin,
  input wire logic read_sel_pin,
  input wire logic [7:0] host_bus_in,
  input wire logic wide_bus,
  input wire logic [7:0] flag_byte,
  input wire logic [7:0] read_byte,
  output lcdie_pkg::lcdie_xfer_t xfer,
  output logic xfer_valid,
  output logic [7:0] host_bus_out,
  output logic host_bus_oe
);
  import lcdie_pkg::*;

  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  logic strobe_d_r;
  logic phase_r;
  logic [3:0] high_nib_r;
  logic fall;
  logic [7:0] src_byte;

  // ==========================================================================
  // Two-stage synchroniser; only the second stage feeds logic.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 11'h000;
      sync2_r <= 11'h000;
      strobe_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {strobe_pin, reg_select_pin, read_sel_pin, host_bus_in};
      sync2_r <= sync1_r;
      strobe_d_r <= sync2_r[10];
    end
  end

  assign fall = strobe_d_r & ~sync2_r[10];
  assign src_byte = sync2_r[9] ? read_byte : flag_byte;

  // ==========================================================================
  // Nibble pairing, high first, for writes and reads alike.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      phase_r <= 1'b0;
      high_nib_r <= 4'h0;
      xfer_valid <= 1'b0;
      xfer <= '0;
    end
    else
    begin
      xfer_valid <= 1'b0;
      if (fall)
      begin
        if (wide_bus)
        begin
          phase_r <= 1'b0;
          xfer_valid <= 1'b1;
          xfer <= '{rs: sync2_r[9], rd: sync2_r[8], data: sync2_r[7:0]};
        end
        else if (!phase_r)
        begin
          phase_r <= 1'b1;
          high_nib_r <= sync2_r[7:4];
        end
        else
        begin
          phase_r <= 1'b0;
          xfer_valid <= 1'b1;
          xfer <= '{rs: sync2_r[9], rd: sync2_r[8], data: {high_nib_r, sync2_r[7:4]}};
        end
      end
    end
  end

  // ==========================================================================
  // Read drive while the strobe is high with read selected.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      host_bus_out <= 8'h00;
      host_bus_oe <= 1'b0;
    end
    else
    begin
      host_bus_oe <= sync2_r[10] & sync2_r[8];
      if (wide_bus)
        host_bus_out <= src_byte;
      else if (!phase_r)
        host_bus_out <= {src_byte[7:4], 4'h0};
      else
        host_bus_out <= {src_byte[3:0], 4'h0};
    end
  end
endmodule // lcdie_host_port
`default_nettype wire

// ---- verilog/lcdie_pkg.sv ----
// Purpose: Shared constants, types and timing for the character display instruction engine.
// Assumes: mclk runs at 200 MHz; the nominal display oscillator is 250 kHz.
// Notes: Times are kept in their own units and turned into cycle counts here.
package lcdie_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_EXEC_NS = 40000;
  localparam int unsigned T_LONG_NS = 1640000;
  localparam int unsigned T_STEP_NS = 6000;
  localparam int unsigned T_BLINK_US = 409600;
  localparam int unsigned EXEC_CYC = (T_EXEC_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LONG_CYC = (T_LONG_NS / CLK_PERIOD_PS) * 1000;
  localparam int unsigned STEP_CYC = (T_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned BLINK_CYC = T_BLINK_US * (1000000 / CLK_PERIOD_PS);

  // ==========================================================================
  // Memory and field layout
  localparam int unsigned TEXT_DEPTH = 128;
  localparam int unsigned GLYPH_DEPTH = 64;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] ROW_LEN_ONE = 7'h50;
  localparam logic [6:0] ROW_LEN_TWO = 7'h28;
  localparam logic [4:0] ROWS_ONE_SHORT = 5'h08;
  localparam logic [4:0] ROWS_ONE_TALL = 5'h0B;
  localparam logic [4:0] ROWS_TWO = 5'h10;
  localparam int unsigned FLAG_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic RST_STEP_UP = 1'b1;
  localparam logic RST_WIDE_BUS = 1'b1;
  localparam logic RST_SEL_TEXT = 1'b1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {DUTY_8, DUTY_11, DUTY_16} lcdie_duty_t;
  typedef enum {ST_IDLE, ST_BUSY, ST_STEP} lcdie_state_t;
  typedef enum {OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_ONOFF, OP_SHIFT, OP_FUNC,
    OP_GLYPH, OP_TEXT, OP_WRITE, OP_READ} lcdie_op_t;

  typedef struct packed {
    logic rs;
    logic rd;
    logic [7:0] data;
  } lcdie_xfer_t;

  typedef struct packed {
    logic panel_on;
    logic pointer_shown;
    logic flash_at_cursor;
  } lcdie_disp_t;

  typedef struct packed {
    logic wide_bus;
    logic two_row;
    logic tall_glyph;
  } lcdie_func_t;

endpackage

// ---- verilog/lcdie_pulse_div.sv ----
// Purpose: Free running divider giving a one-cycle enable pulse every PERIOD cycles.
// Assumes: PERIOD is at least 2.
// Notes: Used as the blink time base.
`timescale 1ns/1ps
`default_nettype none
module lcdie_pulse_div #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (cnt_r == 32'(PERIOD - 1))
    begin
      cnt_r <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule // lcdie_pulse_div
`default_nettype wire
